// ===== rtl/sfcd_decoder.sv
// serial flash command decoder with write-enable and block protection
`default_nettype none
module sfcd_decoder #(
   parameter int MEM_AW = 17, // byte address bits of the array
   parameter int SEC_W = 2, // sector index bits: 2 four, 3 eight
   parameter bit ID_LARGE = 1'b0, // 1 selects the 9Fh id command
   parameter logic [7:0] ID_CODE = 8'h5a // arbitrary id value
) (
   input wire logic clk, // 100 MHz system clock
   input wire logic rst_n, // async reset, active low
   input wire logic serial_clock_in, // host serial clock pin
   input wire logic chip_select_n, // host chip select pin, active low
   input wire logic serial_data_in, // host serial data pin
   output logic serial_data_out, // serial data output pin
   output logic serial_data_oe, // high while data pin is driven
   output logic [23:0] mem_rd_addr, // array read address
   input wire logic [7:0] mem_rd_data, // array data at mem_rd_addr
   output logic pgm_byte_valid, // pulse: page buffer byte
   output logic [7:0] pgm_byte_index, // page buffer slot
   output logic [7:0] pgm_byte_data, // page buffer data
   output logic op_start, // pulse: start internal cycle
   output logic [1:0] op_kind, // kind of internal cycle
   output logic [23:0] op_addr, // target address of cycle
   input wire logic op_done, // pulse: internal cycle finished
   output logic write_in_progress, // busy flag
   output logic write_enable_latch, // write-enable latch
   output logic [2:0] protect_bits // block-protect bits
);
   localparam int NSEC = 1 << SEC_W;
   localparam logic [2:0] BP_MASK = (SEC_W == 2) ? 3'h3 : 3'h7;

   typedef struct packed {
      sfcd_pkg::sfcd_state_e st;
      logic [2:0] bit_cnt;
      logic [1:0] byte_cnt;
      logic [7:0] sh;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [1:0] data_cnt;
      logic [7:0] page_idx;
      logic [2:0] new_bp;
      logic [7:0] out_sh;
      logic [2:0] out_cnt;
      logic dout;
      logic oe;
      logic wel;
      logic wip;
      logic [2:0] bp;
      logic [23:0] rd_addr;
      logic pgm_valid;
      logic [7:0] pgm_idx;
      logic [7:0] pgm_data;
      logic op_start;
      logic [1:0] op_kind;
      logic sclk_d;
      logic cs_d;
   } sfcd_state_s;

   sfcd_state_s r_reg;
   sfcd_state_s r_next;
   logic [2:0] pins_s;
   logic sclk_s;
   logic cs_s;
   logic sdi_s;
   logic sclk_rise;
   logic sclk_fall;
   logic [7:0] byte_in;
   logic [7:0] status_byte;
   logic tgt_prot;
   logic [7:0] first_byte;

   // all three pins come from the host's timing, so all are synchronised
   sfcd_sync #(
      .W(3),
      .RST_VAL(3'h2)
   ) u_pin_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({serial_clock_in, chip_select_n, serial_data_in}),
      .q(pins_s)
   );

   assign sclk_s = pins_s[2];
   assign cs_s = pins_s[1];
   assign sdi_s = pins_s[0];
   assign sclk_rise = sclk_s && !r_reg.sclk_d;
   assign sclk_fall = !sclk_s && r_reg.sclk_d;
   assign byte_in = {r_reg.sh[6:0], sdi_s};

   // live status byte, readable even while a cycle runs
   always_comb begin
      status_byte = 8'h00;
      status_byte[sfcd_pkg::STAT_WIP_BIT] = r_reg.wip;
      status_byte[sfcd_pkg::STAT_WEL_BIT] = r_reg.wel;
      status_byte[sfcd_pkg::STAT_BP_LSB +: 3] = r_reg.bp;
   end

   // protected when the sector lies in the upper area the bits select
   function automatic logic prot_hit(logic [2:0] bp,
                                     logic [SEC_W-1:0] sec);
      logic [SEC_W:0] lim;
      lim = (SEC_W + 1)'(NSEC) - ((SEC_W + 1)'(1) << (bp - 3'h1));
      if (bp == 3'h0) begin
         prot_hit = 1'b0;
      end else if (bp >= 3'(SEC_W + 1)) begin
         prot_hit = 1'b1;
      end else begin
         prot_hit = {1'b0, sec} >= lim;
      end
   endfunction

   assign tgt_prot = prot_hit(r_reg.bp, r_reg.addr[MEM_AW-1 -: SEC_W]);

   // whole command sequencer: pin edges, decode, commit and output
   always_comb begin
      r_next = r_reg;
      first_byte = ID_CODE;
      r_next.pgm_valid = 1'b0;
      r_next.op_start = 1'b0;
      r_next.sclk_d = sclk_s;
      r_next.cs_d = cs_s;
      // end of the internal cycle also drops the latch
      if (op_done && r_reg.wip) begin
         r_next.wip = 1'b0;
         r_next.wel = 1'b0;
      end
      if (cs_s) begin
         r_next.st = sfcd_pkg::ST_IDLE;
         r_next.oe = 1'b0;
         r_next.dout = 1'b0;
         r_next.bit_cnt = 3'h0;
         // commit only on the select rise, and only at a byte boundary
         if (!r_reg.cs_d && r_reg.st != sfcd_pkg::ST_IDLE &&
             r_reg.bit_cnt == 3'h0) begin
            case (r_reg.opcode)
               sfcd_pkg::OP_WREN: begin
                  r_next.wel = 1'b1;
               end
               sfcd_pkg::OP_WRDI: begin
                  r_next.wel = 1'b0;
               end
               sfcd_pkg::OP_WRSR: begin
                  if (r_reg.wel && r_reg.data_cnt == 2'h1) begin
                     r_next.bp = r_reg.new_bp;
                     r_next.op_start = 1'b1;
                     r_next.op_kind = sfcd_pkg::KIND_WRSR;
                     r_next.wip = 1'b1;
                  end
               end
               sfcd_pkg::OP_PP: begin
                  if (r_reg.wel && r_reg.st == sfcd_pkg::ST_IN &&
                      r_reg.data_cnt != 2'h0 && !tgt_prot) begin
                     r_next.op_start = 1'b1;
                     r_next.op_kind = sfcd_pkg::KIND_PP;
                     r_next.wip = 1'b1;
                  end
               end
               sfcd_pkg::OP_SE: begin
                  if (r_reg.wel && r_reg.st == sfcd_pkg::ST_TAIL &&
                      !tgt_prot) begin
                     r_next.op_start = 1'b1;
                     r_next.op_kind = sfcd_pkg::KIND_SE;
                     r_next.wip = 1'b1;
                  end
               end
               sfcd_pkg::OP_BE: begin
                  if (r_reg.wel && r_reg.bp == 3'h0) begin
                     r_next.op_start = 1'b1;
                     r_next.op_kind = sfcd_pkg::KIND_BE;
                     r_next.wip = 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
      end else if (r_reg.cs_d) begin
         // select just fell: a fresh opcode starts at the next rise
         r_next.st = sfcd_pkg::ST_OPCODE;
         r_next.bit_cnt = 3'h0;
         r_next.opcode = sfcd_pkg::OP_NONE;
         r_next.data_cnt = 2'h0;
      end else if (sclk_rise) begin
         // every rise is counted so the byte boundary check stays exact
         r_next.sh = byte_in;
         r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
         if (r_reg.bit_cnt == sfcd_pkg::LAST_BIT) begin
            unique case (r_reg.st)
               sfcd_pkg::ST_OPCODE: begin
                  r_next.opcode = byte_in;
                  r_next.out_cnt = 3'h0;
                  r_next.st = sfcd_pkg::ST_TAIL;
                  // a running cycle leaves only status read open
                  if (r_reg.wip && byte_in != sfcd_pkg::OP_RDSR) begin
                     r_next.opcode = sfcd_pkg::OP_NONE;
                  end else begin
                     case (byte_in)
                        sfcd_pkg::OP_RDSR: begin
                           r_next.st = sfcd_pkg::ST_OUT;
                        end
                        sfcd_pkg::OP_READ, sfcd_pkg::OP_FAST,
                        sfcd_pkg::OP_PP, sfcd_pkg::OP_SE: begin
                           r_next.st = sfcd_pkg::ST_ADDR;
                           r_next.byte_cnt = sfcd_pkg::ADDR_BYTES;
                        end
                        sfcd_pkg::OP_RDID_S: begin
                           if (!ID_LARGE) begin
                              r_next.st = sfcd_pkg::ST_DUMMY;
                              r_next.byte_cnt = sfcd_pkg::ID_S_DUMMY;
                           end else begin
                              r_next.opcode = sfcd_pkg::OP_NONE;
                           end
                        end
                        sfcd_pkg::OP_RDID_L: begin
                           if (ID_LARGE) begin
                              r_next.st = sfcd_pkg::ST_DUMMY;
                              r_next.byte_cnt = sfcd_pkg::ID_L_DUMMY;
                           end else begin
                              r_next.opcode = sfcd_pkg::OP_NONE;
                           end
                        end
                        sfcd_pkg::OP_WRSR: begin
                           r_next.st = sfcd_pkg::ST_IN;
                        end
                        sfcd_pkg::OP_WREN, sfcd_pkg::OP_WRDI,
                        sfcd_pkg::OP_BE: begin
                           r_next.st = sfcd_pkg::ST_TAIL;
                        end
                        default: begin
                           r_next.opcode = sfcd_pkg::OP_NONE;
                        end
                     endcase
                  end
               end
               sfcd_pkg::ST_ADDR: begin
                  r_next.addr = {r_reg.addr[15:0], byte_in};
                  r_next.byte_cnt = r_reg.byte_cnt - 2'h1;
                  if (r_reg.byte_cnt == 2'h1) begin
                     r_next.rd_addr = {r_reg.addr[15:0], byte_in};
                     r_next.page_idx = byte_in;
                     case (r_reg.opcode)
                        sfcd_pkg::OP_READ: begin
                           r_next.st = sfcd_pkg::ST_OUT;
                        end
                        sfcd_pkg::OP_FAST: begin
                           r_next.st = sfcd_pkg::ST_DUMMY;
                           r_next.byte_cnt = sfcd_pkg::FAST_DUMMY;
                        end
                        sfcd_pkg::OP_PP: begin
                           r_next.st = sfcd_pkg::ST_IN;
                        end
                        default: begin
                           r_next.st = sfcd_pkg::ST_TAIL;
                        end
                     endcase
                  end
               end
               sfcd_pkg::ST_DUMMY: begin
                  r_next.byte_cnt = r_reg.byte_cnt - 2'h1;
                  if (r_reg.byte_cnt == 2'h1) begin
                     r_next.st = sfcd_pkg::ST_OUT;
                  end
               end
               sfcd_pkg::ST_IN: begin
                  if (r_reg.opcode == sfcd_pkg::OP_PP) begin
                     // slot wraps, so later bytes overwrite earlier ones
                     r_next.pgm_valid = 1'b1;
                     r_next.pgm_idx = r_reg.page_idx;
                     r_next.pgm_data = byte_in;
                     r_next.page_idx = r_reg.page_idx + 8'h01;
                     r_next.data_cnt = 2'h1;
                  end else begin
                     r_next.new_bp = byte_in[sfcd_pkg::STAT_BP_LSB +: 3]
                                     & BP_MASK;
                     if (r_reg.data_cnt != 2'h2) begin
                        r_next.data_cnt = r_reg.data_cnt + 2'h1;
                     end
                  end
               end
               sfcd_pkg::ST_IDLE, sfcd_pkg::ST_OUT, sfcd_pkg::ST_TAIL: begin
               end
            endcase
         end
      end else if (sclk_fall && r_reg.st == sfcd_pkg::ST_OUT) begin
         // launch on the fall so the host samples on the next rise
         r_next.oe = 1'b1;
         r_next.out_cnt = r_reg.out_cnt + 3'h1;
         if (r_reg.out_cnt == 3'h0) begin
            if (r_reg.opcode == sfcd_pkg::OP_RDSR) begin
               first_byte = status_byte;
            end else if (r_reg.opcode == sfcd_pkg::OP_READ ||
                         r_reg.opcode == sfcd_pkg::OP_FAST) begin
               first_byte = mem_rd_data;
               r_next.rd_addr = r_reg.rd_addr + 24'h000001;
            end
            r_next.dout = first_byte[7];
            r_next.out_sh = {first_byte[6:0], 1'b0};
         end else begin
            r_next.dout = r_reg.out_sh[7];
            r_next.out_sh = {r_reg.out_sh[6:0], 1'b0};
         end
      end
   end

   // latch and protect bits take their power-up values here
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
         r_reg.st <= sfcd_pkg::ST_IDLE;
         r_reg.opcode <= sfcd_pkg::OP_NONE;
         r_reg.wel <= sfcd_pkg::WEL_RST;
         r_reg.bp <= sfcd_pkg::BP_RST;
         r_reg.sclk_d <= 1'b0;
         r_reg.cs_d <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign serial_data_out = r_reg.dout;
   assign serial_data_oe = r_reg.oe;
   assign mem_rd_addr = r_reg.rd_addr;
   assign pgm_byte_valid = r_reg.pgm_valid;
   assign pgm_byte_index = r_reg.pgm_idx;
   assign pgm_byte_data = r_reg.pgm_data;
   assign op_start = r_reg.op_start;
   assign op_kind = r_reg.op_kind;
   assign op_addr = r_reg.addr;
   assign write_in_progress = r_reg.wip;
   assign write_enable_latch = r_reg.wel;
   assign protect_bits = r_reg.bp;

   // checks on the outputs the sequencer drives
   a_oe_after_deselect: assert property (
      @(posedge clk) disable iff (!rst_n)
      cs_s |=> !serial_data_oe)
      else $error("data pin still driven after deselect");
   a_start_needs_wel: assert property (
      @(posedge clk) disable iff (!rst_n)
      op_start |-> $past(r_reg.wel))
      else $error("internal cycle started with latch clear");
   a_start_sets_wip: assert property (
      @(posedge clk) disable iff (!rst_n)
      op_start |-> write_in_progress && !$past(r_reg.wip))
      else $error("busy flag wrong at cycle start");
   a_done_clears_wel: assert property (
      @(posedge clk) disable iff (!rst_n)
      op_done && write_in_progress |=> !r_reg.wel && !r_reg.wip)
      else $error("latch or busy not cleared at cycle end");
   a_bulk_unprotected: assert property (
      @(posedge clk) disable iff (!rst_n)
      op_start && op_kind == sfcd_pkg::KIND_BE |-> protect_bits == 3'h0)
      else $error("bulk erase started with protect bits set");
   a_target_unprot: assert property (
      @(posedge clk) disable iff (!rst_n)
      op_start && (op_kind == sfcd_pkg::KIND_PP ||
                   op_kind == sfcd_pkg::KIND_SE) |-> !tgt_prot)
      else $error("program or erase started in protected area");
   a_start_on_rise: assert property (
      @(posedge clk) disable iff (!rst_n)
      op_start |-> $past(cs_s) && !$past(r_reg.cs_d)
                   && $past(r_reg.bit_cnt) == 3'h0)
      else $error("cycle started off a byte-aligned deselect");
   a_launch_on_fall: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(serial_data_oe) |-> $past(sclk_fall))
      else $error("output enabled away from a falling edge");
endmodule : sfcd_decoder
`default_nettype wire

// ===== rtl/sfcd_pkg.sv
// constants and types shared by the serial flash command decoder
`default_nettype none
package sfcd_pkg;
   // opcodes
   localparam logic [7:0] OP_NONE = 8'h00;
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_PP = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_FAST = 8'h0b;
   localparam logic [7:0] OP_RDID_S = 8'hab;
   localparam logic [7:0] OP_RDID_L = 8'h9f;
   localparam logic [7:0] OP_BE = 8'hc7;
   localparam logic [7:0] OP_SE = 8'hd8;
   // operand byte counts and last bit index of a byte
   localparam logic [1:0] ADDR_BYTES = 2'h3;
   localparam logic [1:0] FAST_DUMMY = 2'h1;
   localparam logic [1:0] ID_S_DUMMY = 2'h3;
   localparam logic [1:0] ID_L_DUMMY = 2'h2;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // status byte layout and reset values
   localparam int STAT_WIP_BIT = 0;
   localparam int STAT_WEL_BIT = 1;
   localparam int STAT_BP_LSB = 2;
   localparam logic [2:0] BP_RST = 3'h0;
   localparam logic WEL_RST = 1'b0;
   // internal cycle kinds handed to the array
   localparam logic [1:0] KIND_PP = 2'h0;
   localparam logic [1:0] KIND_SE = 2'h1;
   localparam logic [1:0] KIND_BE = 2'h2;
   localparam logic [1:0] KIND_WRSR = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_OUT, ST_IN, ST_TAIL
   } sfcd_state_e;
endpackage : sfcd_pkg
`default_nettype wire

// ===== rtl/sfcd_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`default_nettype none
module sfcd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic [W-1:0] d, // asynchronous pin levels
   output logic [W-1:0] q // synchronised levels
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sfcd_sync_s;

   sfcd_sync_s r_reg;
   sfcd_sync_s r_next;

   // first stage feeds only the second stage
   always_comb begin
      r_next = r_reg;
      r_next.s1 = d;
      r_next.s2 = r_reg.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= {RST_VAL, RST_VAL};
      end else begin
         r_reg <= r_next;
      end
   end

   assign q = r_reg.s2;
endmodule : sfcd_sync
`default_nettype wire

// ===== tb/sfcd_host.sv
// host model: drives the serial pins and samples returned data
`default_nettype none
module sfcd_host (
   input wire logic clk, // bench clock
   output logic sck, // serial clock to device
   output logic cs_n, // select, active low
   output logic sdi, // data to device
   input wire logic sdo, // data from device
   input wire logic oe // device drive enable
);
   timeunit 1ns;
   timeprecision 1ps;
   // serial clock parked low and select high between frames
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   // select, then leave setup time before the first rising edge
   task automatic sel();
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // five clocks per level keeps margin over the three-clock minimum
   task automatic xfer(input logic [7:0] tx, input int nb,
      output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nb; i--) begin
         sdi <= tx[i];
         repeat (5) @(posedge clk);
         rx[i] = oe ? sdo : ~sdo; // undriven pin reads garbage
         sck <= 1'b1;
         repeat (5) @(posedge clk);
         sck <= 1'b0;
      end
   endtask
   // released data line flips so a stale level cannot pass
   task automatic desel();
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      sdi <= ~sdi;
      repeat (6) @(posedge clk);
   endtask
endmodule // sfcd_host
`default_nettype wire

// ===== tb/sfcd_decoder_tb.sv
// self-checking testbench for the serial flash command decoder
`default_nettype none
module sfcd_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, sck, cs_n, sdi, sdo, oe, op_done, pv, os, wel, wip;
   logic [7:0] rd_data, pidx, pdat, lidx, ldat, rx;
   logic [23:0] rd_addr, oaddr;
   logic [1:0] okind;
   logic [2:0] bp;
   int fail_count = 0, checks = 0, starts = 0, pbytes = 0;
   localparam logic [7:0] ID_VAL = 8'h5a; // arbitrary id value
   sfcd_decoder #(.ID_CODE(ID_VAL)) sfcd_decoder_i (.clk(clk), .rst_n(rst_n),
      .serial_clock_in(sck), .chip_select_n(cs_n), .serial_data_in(sdi),
      .serial_data_out(sdo), .serial_data_oe(oe), .mem_rd_addr(rd_addr),
      .mem_rd_data(rd_data), .pgm_byte_valid(pv), .pgm_byte_index(pidx),
      .pgm_byte_data(pdat), .op_start(os), .op_kind(okind),
      .op_addr(oaddr), .op_done(op_done), .write_in_progress(wip),
      .write_enable_latch(wel), .protect_bits(bp));
   sfcd_host sfcd_host_i (.clk(clk), .sck(sck), .cs_n(cs_n), .sdi(sdi),
      .sdo(sdo), .oe(oe));
   // free-running bench clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // array model: data one clock after address, cycle and byte counts
   always @(posedge clk) begin
      rd_data <= rd_addr[7:0] ^ 8'h3c;
      if (os) starts <= starts + 1;
      if (pv) begin
         pbytes <= pbytes + 1;
         lidx <= pidx;
         ldat <= pdat;
      end
   end
   task automatic chk(input string nm, input logic [23:0] e, g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // shift n bytes of w, most significant byte first
   task automatic cmd(input logic [47:0] w, input int n, input bit fin);
      sfcd_host_i.sel();
      for (int i = n - 1; i >= 0; i--) sfcd_host_i.xfer(w[8*i+:8], 8, rx);
      if (fin) sfcd_host_i.desel();
   endtask
   // write-type command; checks whether an internal cycle was launched
   task automatic op(input logic [47:0] w, input int n, input bit go,
      input logic [1:0] k, input logic [23:0] a);
      int s0;
      s0 = starts;
      cmd(w, n, 1'b1);
      chk("op_start", 24'(go), 24'(starts - s0));
      if (go) begin
         chk("op_kind", 24'(k), 24'(okind));
         if (k < 2'h2) chk("op_addr", a, oaddr);
         chk("wip busy", 24'h1, 24'(wip));
      end
   endtask
   // array reports the end of the internal cycle
   task automatic finish();
      @(posedge clk);
      op_done <= 1'b1;
      @(posedge clk);
      op_done <= 1'b0;
      repeat (3) @(posedge clk);
      chk("wip idle", 24'h0, 24'(wip));
      chk("latch after cycle", 24'h0, 24'(wel));
   endtask
   task automatic t_latch();
      chk("latch at reset", 24'h0, 24'(wel));
      chk("protect at reset", 24'h0, 24'(bp));
      cmd(48'h06, 1, 1'b1);
      chk("latch set", 24'h1, 24'(wel));
      cmd(48'h05, 1, 1'b0);
      for (int i = 0; i < 2; i++) begin
         sfcd_host_i.xfer(8'h00, 8, rx);
         chk("status", 24'h02, 24'(rx));
      end
      sfcd_host_i.desel();
      cmd(48'h04, 1, 1'b1);
      chk("latch clear", 24'h0, 24'(wel));
      op(48'hd8000000, 4, 1'b0, 2'h0, 24'h0);
   endtask
   task automatic t_program();
      int p0;
      p0 = pbytes;
      cmd(48'h06, 1, 1'b1);
      op(48'h02000010a5c3, 6, 1'b1, sfcd_pkg::KIND_PP, 24'h10);
      chk("page bytes", 24'h2, 24'(pbytes - p0));
      chk("page slot", 24'h11, 24'(lidx));
      chk("page data", 24'hc3, 24'(ldat));
      cmd(48'h05, 1, 1'b0);
      sfcd_host_i.xfer(8'h00, 8, rx);
      chk("busy status", 24'h03, 24'(rx));
      sfcd_host_i.desel();
      cmd(48'h03000000, 4, 1'b0);
      sfcd_host_i.xfer(8'h00, 8, rx);
      chk("busy read drive", 24'h0, 24'(oe));
      sfcd_host_i.desel();
      finish();
   endtask
   task automatic t_partial();
      int s0;
      s0 = starts;
      cmd(48'h06, 1, 1'b1);
      cmd(48'hc7, 1, 1'b0);
      sfcd_host_i.xfer(8'hff, 3, rx);
      sfcd_host_i.desel();
      chk("partial start", 24'h0, 24'(starts - s0));
      chk("latch kept", 24'h1, 24'(wel));
      cmd(48'h04, 1, 1'b1);
   endtask
   // every protect code against every sector, then whole-array erase
   task automatic t_protect();
      bit pr;
      for (int b = 0; b < 5; b++) begin
         cmd(48'h06, 1, 1'b1);
         op({40'h01, 3'h0, 3'(b % 4), 2'h0}, 2, 1'b1,
            sfcd_pkg::KIND_WRSR, 24'h0);
         finish();
         chk("protect", 24'(b % 4), 24'(bp));
         for (int s = 0; s < 4 && b < 4; s++) begin
            pr = (b == 3) || (s >= 4 - b);
            cmd(48'h06, 1, 1'b1);
            // sector index sits in the top two of the 17 address bits
            op({16'h00d8, 24'(s << 15)}, 4, !pr,
               sfcd_pkg::KIND_SE, 24'(s << 15));
            if (pr) cmd(48'h04, 1, 1'b1);
            else finish();
         end
         cmd(48'h06, 1, 1'b1);
         op(48'hc7, 1, b % 4 == 0, sfcd_pkg::KIND_BE, 24'h0);
         if (b % 4 == 0) finish();
         else cmd(48'h04, 1, 1'b1);
      end
   endtask
   task automatic t_read();
      cmd(48'h03000123, 4, 1'b0);
      sfcd_host_i.xfer(8'h00, 8, rx);
      chk("read byte", 24'h1f, 24'(rx));
      sfcd_host_i.xfer(8'h00, 8, rx);
      chk("read next", 24'h18, 24'(rx));
      sfcd_host_i.desel();
      cmd(48'h0b00020000, 5, 1'b0);
      sfcd_host_i.xfer(8'h00, 8, rx);
      sfcd_host_i.desel();
      chk("fast read", 24'h3c, 24'(rx));
      cmd(48'hab000000, 4, 1'b0);
      for (int i = 0; i < 2; i++) begin
         sfcd_host_i.xfer(8'h00, 8, rx);
         chk("id byte", 24'(ID_VAL), 24'(rx));
      end
      sfcd_host_i.desel();
      cmd(48'h03000000, 4, 1'b0);
      sfcd_host_i.xfer(8'h00, 3, rx);
      sfcd_host_i.desel();
      chk("drive after abort", 24'h0, 24'(oe));
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // main sequence after a two-cycle reset
   initial begin
      rst_n = 1'b0;
      op_done = 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_latch();
      t_program();
      t_partial();
      t_protect();
      t_read();
      test_done();
   end
   // watchdog sized well beyond the expected run length
   initial begin
      repeat (90000) @(posedge clk);
      fail_count++;
      test_done();
   end
endmodule // sfcd_decoder_tb
`default_nettype wire
